/* logic/nvac_top.v */
// Nonvolatile access controller: control register, holding registers, write/read sequencing.
// Assumes a byte register port on clk_sys and external memory arrays on plain ports.
// Assumes warm_rst_n is asynchronous and the arrays commit on one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
`include "nvac_consts.vh"

module nvac_top #(
  parameter EE_WR_CYC = `NVAC_EE_WR_CYC,
  parameter FL_WR_CYC = `NVAC_FL_WR_CYC
) (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire        warm_rst_n,
  input  wire [8:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  output reg         core_stall,
  output reg         irq,
  output reg         ee_wr_en,
  output reg  [7:0]  ee_addr,
  output reg  [7:0]  ee_wdata,
  input  wire [7:0]  ee_rdata,
  output reg         fl_wr_en,
  output reg  [12:0] fl_addr,
  output reg  [13:0] fl_wdata
);
  // Sequencer states
  localparam ST_IDLE = 2'd0;
  localparam ST_EE   = 2'd1;
  localparam ST_FL   = 2'd2;

  // Warm reset pin from outside: two stages before use
  // The third stage only delays the synchronised level for edge detection;
  // idle level is high so no false edge follows power-on reset
  reg        wr_s1_reg;
  reg        wr_s2_reg;
  reg        wr_s3_reg;
  wire       warm_hit = !wr_s2_reg && wr_s3_reg;

  // Control register bits, holding registers, status and sequencer state
  reg        space_reg;
  reg        intr_reg;
  reg        permit_reg;
  reg        trig_reg;
  reg        read_reg;
  reg [7:0]  addr_lo_reg;
  reg [4:0]  addr_hi_reg;
  reg [7:0]  data_lo_reg;
  reg [5:0]  data_hi_reg;
  reg [1:0]  stat_reg;
  reg [1:0]  mask_reg;
  reg [1:0]  state_reg;

  // Register port decodes and start conditions
  wire       armed;
  wire       t_busy;
  wire       t_done;
  wire [19:0] t_count;
  wire       key_wr  = reg_wr && reg_addr == `NVAC_OFF_KEY;
  wire       ctrl_wr = reg_wr && reg_addr == `NVAC_OFF_CTRL;
  wire       alo_wr  = reg_wr && reg_addr == `NVAC_OFF_ADDR_LO;
  wire       ahi_wr  = reg_wr && reg_addr == `NVAC_OFF_ADDR_HI;
  wire       dlo_wr  = reg_wr && reg_addr == `NVAC_OFF_DATA_LO;
  wire       dhi_wr  = reg_wr && reg_addr == `NVAC_OFF_DATA_HI;
  wire       stat_wr = reg_wr && reg_addr == `NVAC_OFF_IRQ_STAT;
  wire       mask_wr = reg_wr && reg_addr == `NVAC_OFF_IRQ_MASK;
  // A warm reset idles the sequencer but cannot stop the timer, so a leftover
  // count must hold off the next start too, or its done pulse would end it early
  wire       busy    = state_reg != ST_IDLE || read_reg || t_busy;
  // Permit must already be set from an earlier write, plus key sequence
  wire       go_wr   = ctrl_wr && reg_wdata[`NVAC_BIT_TRIG] && !trig_reg && permit_reg && armed
                       && !busy;
  wire       go_rd   = ctrl_wr && reg_wdata[`NVAC_BIT_READ] && !busy;
  wire       ev_done = state_reg != ST_IDLE && t_done;
  // A warm reset only counts as a cut write while a cycle is running
  wire       abort_wr = warm_hit && state_reg != ST_IDLE;

  // Count chosen by the space select, which cannot change mid-cycle
  assign t_count = space_reg ? FL_WR_CYC[19:0] : EE_WR_CYC[19:0];

  // Key sequence; any other register write in between disarms it
  // Reads do not disarm it, so firmware may poll between the steps
  nvac_unlock u_unlock (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .any_wr    (reg_wr),
    .key_wr    (key_wr),
    .wdata     (reg_wdata),
    .armed_reg (armed)
  );

  // One timer for both spaces; its count is taken at start
  // Its busy flag also guards starts after a warm reset
  nvac_timer #(.WIDTH(20)) u_timer (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .start    (go_wr),
    .count    (t_count),
    .busy_reg (t_busy),
    .done_reg (t_done)
  );

  // Synchroniser and edge of warm reset assertion
  // A low pulse shorter than one clock period may be missed
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_s1_reg <= 1'b1;
      wr_s2_reg <= 1'b1;
      wr_s3_reg <= 1'b1;
    end else begin
      wr_s1_reg <= warm_rst_n;
      wr_s2_reg <= wr_s1_reg;
      wr_s3_reg <= wr_s2_reg;
    end
  end

  // Holding registers and space select: power-on reset only, warm reset leaves them
  // Read data wins over a firmware write in the same cycle, so a read
  // started just before the write is never lost
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      space_reg   <= 1'b0;
      addr_lo_reg <= 8'h00;
      addr_hi_reg <= 5'h00;
      data_lo_reg <= 8'h00;
      data_hi_reg <= 6'h00;
    end else begin
      if (ctrl_wr && !busy) begin
        space_reg <= reg_wdata[`NVAC_BIT_SPACE];
      end
      if (alo_wr) begin
        addr_lo_reg <= reg_wdata;
      end
      if (ahi_wr) begin
        addr_hi_reg <= reg_wdata[4:0];
      end
      if (read_reg) begin
        data_lo_reg <= ee_rdata;
      end else if (dlo_wr) begin
        data_lo_reg <= reg_wdata;
      end
      if (dhi_wr) begin
        data_hi_reg <= reg_wdata[5:0];
      end
    end
  end

  // Control bits and sequencer; warm reset aborts a write and records it
  // Permit and the error bit follow every control write not met by a warm reset in the same cycle; trigger and read
  // start only ever go high from software and low from hardware
  // Limitation: a write cut by warm reset is not retried here
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      intr_reg   <= 1'b0;
      permit_reg <= 1'b0;
      trig_reg   <= 1'b0;
      read_reg   <= 1'b0;
      state_reg  <= ST_IDLE;
    end else if (warm_hit) begin
      // Warm reset: drop permit and any pending start, keep the error record
      intr_reg   <= abort_wr ? 1'b1 : intr_reg;
      permit_reg <= 1'b0;
      trig_reg   <= 1'b0;
      read_reg   <= 1'b0;
      state_reg  <= ST_IDLE;
    end else begin
      // Read start lives one cycle; data lands on the next edge
      read_reg <= go_rd && !reg_wdata[`NVAC_BIT_SPACE] && !space_reg;
      if (ctrl_wr) begin
        permit_reg <= reg_wdata[`NVAC_BIT_PERMIT];
        intr_reg   <= reg_wdata[`NVAC_BIT_INTR];
      end
      case (state_reg)
        ST_IDLE: begin
          // go_wr is refused while busy, so one cycle at a time
          if (go_wr) begin
            trig_reg  <= 1'b1;
            state_reg <= space_reg ? ST_FL : ST_EE;
          end
        end
        ST_EE, ST_FL: begin
          // Normal end: the error bit reads zero unless written now
          if (t_done) begin
            trig_reg  <= 1'b0;
            state_reg <= ST_IDLE;
            if (!(ctrl_wr && reg_wdata[`NVAC_BIT_INTR])) begin
              intr_reg <= 1'b0;
            end
          end
        end
        // Unused code falls back to idle
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Memory write strobes, stall and addresses
  // Addresses and data are copied every cycle; the commit pulse uses the
  // holding registers as they stand when the timed cycle ends
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ee_wr_en   <= 1'b0;
      fl_wr_en   <= 1'b0;
      core_stall <= 1'b0;
      ee_addr    <= 8'h00;
      ee_wdata   <= 8'h00;
      fl_addr    <= 13'h0000;
      fl_wdata   <= 14'h0000;
    end else begin
      // Array commits at cycle end; erase is implied by the timed cycle
      ee_wr_en   <= ev_done && state_reg == ST_EE && !warm_hit;
      fl_wr_en   <= ev_done && state_reg == ST_FL && !warm_hit;
      // Stall rises with an accepted program-space start so no later instruction slips past;
      // commits are suppressed when a warm reset lands on the last cycle
      core_stall <= (state_reg == ST_FL || (go_wr && space_reg)) && !ev_done && !warm_hit;
      ee_addr    <= addr_lo_reg;
      ee_wdata   <= data_lo_reg;
      fl_addr    <= {addr_hi_reg, addr_lo_reg};
      fl_wdata   <= {data_hi_reg, data_lo_reg};
    end
  end

  // Sticky status events and write-one clears, one column per bit
  wire [1:0] stat_set;
  wire [1:0] stat_clr;
  assign stat_set[`NVAC_IRQ_DONE] = ev_done && !warm_hit;
  assign stat_set[`NVAC_IRQ_INTR] = abort_wr;
  assign stat_clr = stat_wr ? reg_wdata[1:0] : 2'b00;

  // Sticky status: set wins over write-one clear so no event is ever lost
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_stat
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          stat_reg[gi] <= 1'b0;
        end else begin
          stat_reg[gi] <= stat_set[gi] || (stat_reg[gi] && !stat_clr[gi]);
        end
      end
    end
  endgenerate

  // Mask and level interrupt; one cycle behind the status it reflects
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= `NVAC_MASK_RST;
      irq      <= 1'b0;
    end else begin
      if (mask_wr) begin
        mask_reg <= reg_wdata[1:0];
      end
      irq <= |(stat_reg & mask_reg);
    end
  end

  // Read port; unmapped addresses read zero
  // Zero outside the answer cycle keeps the bus quiet, so a caller that
  // samples one cycle late sees zero rather than stale data
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        // Bits 6 to 4 of the control register are unused and read zero
        `NVAC_OFF_CTRL:     reg_rdata <= {space_reg, 3'b000, intr_reg, permit_reg, trig_reg, read_reg};
        `NVAC_OFF_ADDR_LO:  reg_rdata <= addr_lo_reg;
        `NVAC_OFF_ADDR_HI:  reg_rdata <= {3'b000, addr_hi_reg};
        `NVAC_OFF_DATA_LO:  reg_rdata <= data_lo_reg;
        `NVAC_OFF_DATA_HI:  reg_rdata <= {2'b00, data_hi_reg};
        `NVAC_OFF_IRQ_STAT: reg_rdata <= {6'h00, stat_reg};
        `NVAC_OFF_IRQ_MASK: reg_rdata <= {6'h00, mask_reg};
        default:            reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

/* logic/nvac_consts.vh */
// Constants for the nonvolatile access controller: offsets, fields, resets, timing.
// Assumes byte-wide register port with 9-bit addresses.
`ifndef NVAC_CONSTS_VH
`define NVAC_CONSTS_VH

// Register offsets
`define NVAC_OFF_CTRL       9'h18C
`define NVAC_OFF_KEY        9'h18D
`define NVAC_OFF_ADDR_LO    9'h10D
`define NVAC_OFF_DATA_LO    9'h10C
`define NVAC_OFF_ADDR_HI    9'h10F
`define NVAC_OFF_DATA_HI    9'h10E
`define NVAC_OFF_IRQ_STAT   9'h190
`define NVAC_OFF_IRQ_MASK   9'h191

// Control register fields
`define NVAC_BIT_SPACE      7
`define NVAC_BIT_INTR       3
`define NVAC_BIT_PERMIT     2
`define NVAC_BIT_TRIG       1
`define NVAC_BIT_READ       0

// Interrupt status fields
`define NVAC_IRQ_DONE       0
`define NVAC_IRQ_INTR       1

// Unlock key values
`define NVAC_KEY1           8'h55
`define NVAC_KEY2           8'hAA

// Reset values
`define NVAC_CTRL_RST       8'h00
`define NVAC_MASK_RST       2'h0

// Timing: data write and flash write times in microseconds
`define NVAC_EE_WR_US       4000
`define NVAC_FL_WR_US       4000
`define NVAC_CLK_MHZ        10
`define NVAC_EE_WR_CYC      (`NVAC_EE_WR_US * `NVAC_CLK_MHZ)
`define NVAC_FL_WR_CYC      (`NVAC_FL_WR_US * `NVAC_CLK_MHZ)

`endif

/* logic/nvac_unlock.v */
// Unlock key sequencer: arms a write trigger after 55h then AAh.
// Assumes same-clock register strobes from the register port.
`timescale 1ns/1ps
`default_nettype none
`include "nvac_consts.vh"

module nvac_unlock (
  input  wire       clk_sys,
  input  wire       rst_n,
  input  wire       any_wr,
  input  wire       key_wr,
  input  wire [7:0] wdata,
  output reg        armed_reg
);
  reg       half_reg;
  reg       half_next;
  reg       armed_next;

  // Any other write between the keys and the trigger breaks the sequence
  always @* begin
    half_next  = 1'b0;
    armed_next = 1'b0;
    if (key_wr && wdata == `NVAC_KEY1) begin
      half_next = 1'b1;
    end else if (key_wr && wdata == `NVAC_KEY2 && half_reg) begin
      armed_next = 1'b1;
    end else if (!any_wr) begin
      half_next  = half_reg;
      armed_next = armed_reg;
    end
  end

  // Key state
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      half_reg  <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      half_reg  <= half_next;
      armed_reg <= armed_next;
    end
  end
endmodule
`default_nettype wire

/* logic/nvac_timer.v */
// Self-timed cycle counter for erase-then-write operations.
// Assumes start is a one-cycle pulse while idle.
`timescale 1ns/1ps
`default_nettype none

module nvac_timer #(
  parameter WIDTH = 20
) (
  input  wire             clk_sys,
  input  wire             rst_n,
  input  wire             start,
  input  wire [WIDTH-1:0] count,
  output reg              busy_reg,
  output reg              done_reg
);
  reg [WIDTH-1:0] cnt_reg;

  // Count down; done pulses one cycle after the last count
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= {WIDTH{1'b0}};
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (start && !busy_reg) begin
        cnt_reg  <= count;
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        if (cnt_reg <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule
`default_nettype wire

/* tb/nvac_chk.sv */
// Port-level checks on the access controller.
// Assumes one clock domain and the async power-on reset.
`timescale 1ns/1ps
`default_nettype none
`include "nvac_consts.vh"
module nvac_chk #(
  parameter FL_WR_CYC = 8
) (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic [8:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       core_stall,
  input wire logic       ee_wr_en,
  input wire logic       fl_wr_en
);
  logic        key2_reg;
  logic [31:0] stall_cnt_reg;
  // Key history and stall length; a long stall would hang the core
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      key2_reg      <= 1'b0;
      stall_cnt_reg <= 32'h0000_0000;
    end else begin
      // Second key stays live across reads; any other write drops it
      if (reg_wr) begin
        key2_reg <= reg_addr == `NVAC_OFF_KEY && reg_wdata == `NVAC_KEY2;
      end
      stall_cnt_reg <= core_stall ? stall_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  ee_pulse_a: assert property (ee_wr_en |=> !ee_wr_en)
    else $error("data commit too long");
  fl_pulse_a: assert property (fl_wr_en |=> !fl_wr_en)
    else $error("program commit too long");
  one_space_a: assert property (!(ee_wr_en && fl_wr_en))
    else $error("both spaces committed");
  ee_runs_a: assert property (ee_wr_en |-> !core_stall)
    else $error("core stalled on data write");
  fl_stalled_a: assert property (fl_wr_en |-> core_stall || $past(core_stall))
    else $error("program commit without stall");
  stall_bound_a: assert property (stall_cnt_reg <= FL_WR_CYC + 4)
    else $error("stall too long");
  no_key_a: assert property (reg_wr && reg_addr == `NVAC_OFF_CTRL && reg_wdata[1] && !key2_reg
    && !core_stall |=> !core_stall [*3])
    else $error("start without keys");
endmodule
`default_nettype wire

/* tb/nvac_mem_model.sv */
// Behavioural data array and last program write record behind the controller.
// Assumes one-cycle commit pulses; data reads are combinational.
`timescale 1ns/1ps
`default_nettype none
module nvac_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        ee_wr_en,
  input  wire logic [7:0]  ee_addr,
  input  wire logic [7:0]  ee_wdata,
  output var  logic [7:0]  ee_rdata,
  input  wire logic        fl_wr_en,
  input  wire logic [12:0] fl_addr,
  input  wire logic [13:0] fl_wdata,
  output var  logic [12:0] fl_last_addr,
  output var  logic [13:0] fl_last_word
);
  logic [7:0] ee_mem [0:255];
  // Distinct bytes so a stale read shows up
  initial begin
    for (int i = 0; i < 256; i++) ee_mem[i] = ~i[7:0];
    fl_last_addr = 13'h0000;
    fl_last_word = 14'h0000;
  end
  assign ee_rdata = ee_mem[ee_addr];
  // Erase then write collapses to one store per commit
  always @(posedge clk_sys) begin
    if (ee_wr_en) ee_mem[ee_addr] <= ee_wdata;
    if (fl_wr_en) begin
      fl_last_addr <= fl_addr;
      fl_last_word <= fl_wdata;
    end
  end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the access controller and memory model.
// Assumes short write times set below and the one-cycle register port.
`timescale 1ns/1ps
`default_nettype none
`include "nvac_consts.vh"
module testbench;
  localparam int CYC = 20;
  logic        clk_sys, rst_n, warm_rst_n, reg_wr, reg_rd, core_stall, irq, ee_wr_en, fl_wr_en;
  logic [8:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, ee_addr, ee_wdata, ee_rdata, rv;
  logic [12:0] fl_addr, fl_last_addr;
  logic [13:0] fl_wdata, fl_last_word;
  int          failures, num_checks, n;
  nvac_top #(.EE_WR_CYC(CYC), .FL_WR_CYC(CYC)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .warm_rst_n(warm_rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_stall(core_stall), .irq(irq), .ee_wr_en(ee_wr_en),
    .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_rdata(ee_rdata), .fl_wr_en(fl_wr_en),
    .fl_addr(fl_addr), .fl_wdata(fl_wdata));
  nvac_mem_model i_mem (.clk_sys(clk_sys), .ee_wr_en(ee_wr_en), .ee_addr(ee_addr),
    .ee_wdata(ee_wdata), .ee_rdata(ee_rdata), .fl_wr_en(fl_wr_en), .fl_addr(fl_addr),
    .fl_wdata(fl_wdata), .fl_last_addr(fl_last_addr), .fl_last_word(fl_last_word));
  // 10 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task rd(input logic [8:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task rdc(input logic [8:0] a, input logic [7:0] e);
    rd(a);
    chk(rv, e);
  endtask
  task unlock;
    wr(`NVAC_OFF_KEY, `NVAC_KEY1);
    wr(`NVAC_OFF_KEY, `NVAC_KEY2);
  endtask
  task wait_done;
    n = 0;
    rd(`NVAC_OFF_CTRL);
    while (rv[1] !== 1'b0 && n < 60) begin
      rd(`NVAC_OFF_CTRL);
      n++;
    end
    chk(n < 60, 1'b1);
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Hang guard, far beyond the expected run
  initial begin
    #(100 * 20000);
    failures++;
    print_verdict;
  end
  initial begin
    rst_n      = 1'b0;
    warm_rst_n = 1'b1;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    reg_addr   = 9'h000;
    reg_wdata  = 8'h00;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Reset values and an unmapped place
    rdc(`NVAC_OFF_CTRL, `NVAC_CTRL_RST);
    rdc(`NVAC_OFF_IRQ_MASK, 8'h00);
    rdc(9'h1FF, 8'h00);
    wr(`NVAC_OFF_CTRL, 8'h00);
    // Refused starts: no permit, permit in same write, keys missing
    wr(`NVAC_OFF_ADDR_LO, 8'h21);
    wr(`NVAC_OFF_DATA_LO, 8'h5A);
    unlock;
    wr(`NVAC_OFF_CTRL, 8'h02);
    rdc(`NVAC_OFF_CTRL, 8'h00);
    unlock;
    wr(`NVAC_OFF_CTRL, 8'h06);
    rdc(`NVAC_OFF_CTRL, 8'h04);
    wr(`NVAC_OFF_CTRL, 8'h06);
    rdc(`NVAC_OFF_CTRL, 8'h04);
    chk(i_mem.ee_mem[8'h21], 8'hDE);
    // Accepted data write, interrupt unmasked
    wr(`NVAC_OFF_IRQ_MASK, 8'h01);
    unlock;
    wr(`NVAC_OFF_CTRL, 8'h06);
    rdc(`NVAC_OFF_CTRL, 8'h06);
    wr(`NVAC_OFF_CTRL, 8'h84);
    rdc(`NVAC_OFF_CTRL, 8'h06);
    wait_done;
    chk(rv, 8'h04);
    rdc(`NVAC_OFF_IRQ_STAT, 8'h01);
    chk(irq, 1'b1);
    chk(i_mem.ee_mem[8'h21], 8'h5A);
    wr(`NVAC_OFF_IRQ_STAT, 8'h01);
    rdc(`NVAC_OFF_IRQ_STAT, 8'h00);
    chk(irq, 1'b0);
    // Read path
    wr(`NVAC_OFF_ADDR_LO, 8'h07);
    wr(`NVAC_OFF_CTRL, 8'h01);
    rdc(`NVAC_OFF_CTRL, 8'h00);
    rdc(`NVAC_OFF_DATA_LO, 8'hF8);
    wr(`NVAC_OFF_DATA_LO, 8'h3C);
    rdc(`NVAC_OFF_DATA_LO, 8'h3C);
    // Program word write with interrupt masked
    wr(`NVAC_OFF_IRQ_MASK, 8'h00);
    wr(`NVAC_OFF_ADDR_HI, 8'h1A);
    wr(`NVAC_OFF_DATA_HI, 8'h2B);
    wr(`NVAC_OFF_CTRL, 8'h84);
    wr(`NVAC_OFF_CTRL, 8'h86);
    rdc(`NVAC_OFF_CTRL, 8'h84);
    unlock;
    wr(`NVAC_OFF_CTRL, 8'h86);
    repeat (2) @(posedge clk_sys);
    #1 chk(core_stall, 1'b1);
    n = 0;
    while (core_stall !== 1'b0 && n < 60) begin
      @(posedge clk_sys);
      n++;
    end
    chk(n < 60, 1'b1);
    repeat (2) @(posedge clk_sys);
    #1;
    chk(fl_last_addr, 13'h1A07);
    chk(fl_last_word, 14'h2B3C);
    rdc(`NVAC_OFF_CTRL, 8'h84);
    rdc(`NVAC_OFF_IRQ_STAT, 8'h01);
    chk(irq, 1'b0);
    wr(`NVAC_OFF_CTRL, 8'h85);
    rdc(`NVAC_OFF_CTRL, 8'h84);
    rdc(`NVAC_OFF_DATA_LO, 8'h3C);
    wr(`NVAC_OFF_IRQ_STAT, 8'h01);
    // Warm reset in mid-write
    wr(`NVAC_OFF_CTRL, 8'h04);
    unlock;
    wr(`NVAC_OFF_CTRL, 8'h06);
    repeat (2) @(posedge clk_sys);
    warm_rst_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    warm_rst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rdc(`NVAC_OFF_CTRL, 8'h08);
    rdc(`NVAC_OFF_ADDR_LO, 8'h07);
    rdc(`NVAC_OFF_DATA_LO, 8'h3C);
    rdc(`NVAC_OFF_ADDR_HI, 8'h1A);
    rdc(`NVAC_OFF_IRQ_STAT, 8'h02);
    print_verdict;
  end
endmodule
bind nvac_top nvac_chk #(.FL_WR_CYC(FL_WR_CYC)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .core_stall(core_stall), .ee_wr_en(ee_wr_en), .fl_wr_en(fl_wr_en));
`default_nettype wire
